// ==== pkg/dfpc_pkg.sv ====
// dfpc_pkg: constants and carrier types for the data fifo path control
// assumes one clock domain; register offsets are byte addresses
package dfpc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] DFPC_OFS_CONTROL = 8'h90;
   localparam logic [7:0] DFPC_OFS_STATUS = 8'h94;
   localparam logic [7:0] DFPC_OFS_CACHE_SIZE = 8'h98;
   localparam logic [7:0] DFPC_OFS_HOST_ADDR0 = 8'h9C;
   localparam logic [7:0] DFPC_OFS_BLOCK_CTRL = 8'hA0;
   localparam logic [7:0] DFPC_OFS_DATA_PORT = 8'hA4;

   // control register fields
   localparam int DFPC_CTL_CLEAR = 0;
   localparam int DFPC_CTL_DRAIN = 1;
   localparam int DFPC_CTL_DIR = 2;
   localparam int DFPC_CTL_HOST_EN = 3;
   localparam int DFPC_CTL_SDMA_EN = 4;
   localparam int DFPC_CTL_SBUS_EN = 5;
   localparam int DFPC_CTL_WIDE_ODD = 6;
   // block control register fields
   localparam int DFPC_BLK_AUTO_DIS = 0;
   localparam int DFPC_BLK_SOFT_RST = 1;
   // status register fields
   localparam int DFPC_ST_EMPTY = 0;
   localparam int DFPC_ST_FULL = 1;
   localparam int DFPC_ST_FILL_TH = 2;
   localparam int DFPC_ST_HOST_DONE_FLAG = 3;
   localparam int DFPC_ST_MREQ = 4;
   localparam int DFPC_ST_QW_EMPTY = 5;
   localparam int DFPC_ST_CACHE_TH = 6;

   // ----------------------------------------------------------------
   // fifo geometry and thresholds
   // ----------------------------------------------------------------
   localparam logic [8:0] DFPC_DEPTH = 9'h100;
   localparam logic [8:0] DFPC_QWORD = 9'h008;
   localparam logic [7:0] DFPC_CLS_8 = 8'h08;
   localparam logic [7:0] DFPC_CLS_16 = 8'h10;
   localparam logic [7:0] DFPC_CLS_32 = 8'h20;
   localparam logic [8:0] DFPC_TH_16 = 9'h010;
   localparam logic [8:0] DFPC_TH_32 = 9'h020;
   localparam logic [8:0] DFPC_TH_64 = 9'h040;
   localparam logic [8:0] DFPC_TH_128 = 9'h080;
   localparam logic [7:0] DFPC_RESET_BYTE = 8'h00;

   // one byte on a streaming side
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } dfpc_byte_s;

endpackage

// ==== rtl/dfpc_top.sv ====
// dfpc_top: data fifo, its direction and drain control, and status
// assumes host and scsi blocks run on I_CLK_SYS; bus reset is synchronous
// to it; firmware reaches registers over the plain strobe port
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module dfpc_top
   import dfpc_pkg::*;
(
   input wire logic I_CLK_SYS,
   input wire logic I_ARST_N,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   input wire dfpc_byte_s I_HOST_IN,
   output logic O_HOST_IN_READY,
   output dfpc_byte_s O_HOST_OUT,
   input wire logic I_HOST_OUT_READY,
   input wire dfpc_byte_s I_SCSI_IN,
   output logic O_SCSI_IN_READY,
   output dfpc_byte_s O_SCSI_OUT,
   input wire logic I_SCSI_OUT_READY,
   input wire logic I_SCSI_COUNT_ZERO,
   input wire logic I_PHASE_CHANGE,
   input wire logic I_BUS_RESET,
   input wire logic I_MEM_REQ_PENDING,
   input wire logic I_HOST_DONE,
   input wire logic I_FILL_THRESHOLD,
   output logic O_HOST_XFER_EN,
   output logic O_SCSI_DMA_EN,
   output logic O_SCSI_BUS_EN,
   output logic O_PATH_FLOW,
   output logic O_DRAIN_ACTIVE,
   output logic O_WIDE_ODD,
   output logic O_OFFSET_LOAD,
   output logic [2:0] O_BYTE_OFFSET
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // bytes needed for one burst; inbound picks the free-space figure
   function automatic logic [8:0] burst_bytes(input logic [7:0] cls,
                                              input logic inbound);
      logic [8:0] b;
      b = DFPC_TH_128;
      if (cls < DFPC_CLS_8) begin
         b = inbound ? DFPC_TH_32 : DFPC_TH_16;
      end else if (cls < DFPC_CLS_16) begin
         b = DFPC_TH_32;
      end else if (cls < DFPC_CLS_32) begin
         b = DFPC_TH_64;
      end
      return b;
   endfunction

   function automatic logic reg_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] mem_q [0:255];
   logic [8:0] wr_ptr_q, rd_ptr_q;
   logic [8:0] count, free;
   logic [2:0] en_q, ack_q;
   logic dir_q, dir_ack_q, wide_odd_q, auto_dis_q;
   logic drain_q, drain_set;
   logic clear_q, soft_q;
   logic [7:0] cls_q, haddr0_q;
   logic wr_en, rd_en;
   logic [7:0] wr_data;
   logic seq_wr, seq_rd, hw_idle, force_clr;
   logic flag_empty, flag_full, flag_qw_empty, flag_cache;
   logic [7:0] status;
   logic wr_ctl, clr_wr;

   assign count = wr_ptr_q - rd_ptr_q;
   assign free = DFPC_DEPTH - count;
   assign hw_idle = ~ack_q[0] & ~ack_q[1];
   assign wr_ctl = I_WR & reg_hit(I_ADDR, DFPC_OFS_CONTROL);
   assign clr_wr = wr_ctl & I_WDATA[DFPC_CTL_CLEAR];
   assign force_clr = clear_q | soft_q | I_BUS_RESET;

   // ----------------------------------------------------------------
   // flags and status
   // ----------------------------------------------------------------
   // empty, full and quad-word flags forced while clear or either reset is active
   always_comb begin
      flag_empty = (count == 9'h000) | force_clr;
      flag_full = (count == DFPC_DEPTH) & ~force_clr;
      flag_qw_empty = (count < DFPC_QWORD) | force_clr;
      if (dir_ack_q) begin
         flag_cache = free >= burst_bytes(cls_q, 1'b1);
      end else begin
         flag_cache = count >= burst_bytes(cls_q, 1'b0);
      end
   end

   // read-only status image, bit seven tied low
   always_comb begin
      status = DFPC_RESET_BYTE;
      status[DFPC_ST_EMPTY] = flag_empty;
      status[DFPC_ST_FULL] = flag_full;
      status[DFPC_ST_FILL_TH] = I_FILL_THRESHOLD;
      status[DFPC_ST_HOST_DONE_FLAG] = I_HOST_DONE;
      status[DFPC_ST_MREQ] = I_MEM_REQ_PENDING;
      status[DFPC_ST_QW_EMPTY] = flag_qw_empty;
      status[DFPC_ST_CACHE_TH] = flag_cache;
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // enables, wide odd, cache size, host address, auto drain disable
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         en_q <= 3'h0;
         wide_odd_q <= 1'b0;
         dir_q <= 1'b0;
         cls_q <= DFPC_RESET_BYTE;
         haddr0_q <= DFPC_RESET_BYTE;
         auto_dis_q <= 1'b0;
      end else begin
         if (wr_ctl) begin
            en_q <= I_WDATA[DFPC_CTL_SBUS_EN:DFPC_CTL_HOST_EN];
            wide_odd_q <= I_WDATA[DFPC_CTL_WIDE_ODD];
            dir_q <= I_WDATA[DFPC_CTL_DIR];
         end
         if (I_WR && reg_hit(I_ADDR, DFPC_OFS_CACHE_SIZE)) begin
            cls_q <= I_WDATA;
         end
         if (I_WR && reg_hit(I_ADDR, DFPC_OFS_HOST_ADDR0)) begin
            haddr0_q <= I_WDATA;
         end
         if (I_WR && reg_hit(I_ADDR, DFPC_OFS_BLOCK_CTRL)) begin
            auto_dis_q <= I_WDATA[DFPC_BLK_AUTO_DIS];
         end
      end
   end

   // acks trail enables by one cycle; direction ack moves only when idle
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ack_q <= 3'h0;
         dir_ack_q <= 1'b0;
      end else begin
         ack_q <= en_q;
         if (en_q == 3'h0 && ack_q == 3'h0) begin
            dir_ack_q <= dir_q;
         end
      end
   end

   // self-clearing strobes: clear and soft reset
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         clear_q <= 1'b0;
         soft_q <= 1'b0;
      end else begin
         clear_q <= clr_wr;
         soft_q <= I_WR & reg_hit(I_ADDR, DFPC_OFS_BLOCK_CTRL) &
                   I_WDATA[DFPC_BLK_SOFT_RST];
      end
   end

   // ----------------------------------------------------------------
   // drain control
   // ----------------------------------------------------------------
   // manual only toward host or while sequencer loads; auto toward host
   always_comb begin
      drain_set = 1'b0;
      if (!flag_empty) begin
         if (wr_ctl && I_WDATA[DFPC_CTL_DRAIN] &&
             (!dir_ack_q || hw_idle)) begin
            drain_set = 1'b1;
         end
         if (!auto_dis_q && !dir_ack_q &&
             (I_SCSI_COUNT_ZERO || I_PHASE_CHANGE)) begin
            drain_set = 1'b1;
         end
      end
   end

   // pending until the fifo runs dry; a new request beats completion
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         drain_q <= 1'b0;
      end else if (clr_wr || force_clr) begin
         drain_q <= 1'b0;
      end else if (drain_set) begin
         drain_q <= 1'b1;
      end else if (flag_empty) begin
         drain_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // fifo data path
   // ----------------------------------------------------------------
   assign seq_wr = I_WR & reg_hit(I_ADDR, DFPC_OFS_DATA_PORT) &
                   ~flag_full;
   assign seq_rd = I_RD & reg_hit(I_ADDR, DFPC_OFS_DATA_PORT) &
                   ~flag_empty;

   // writer and reader chosen by direction ack; sequencer has priority
   always_comb begin
      O_HOST_IN_READY = dir_ack_q & ack_q[0] & ~flag_full & ~seq_wr;
      O_SCSI_IN_READY = ~dir_ack_q & ack_q[1] & ~flag_full & ~seq_wr;
      O_HOST_OUT.valid = ~dir_ack_q & ack_q[0] & ~seq_rd &
                         (~flag_qw_empty | (drain_q & ~flag_empty));
      O_SCSI_OUT.valid = dir_ack_q & ack_q[1] & ~seq_rd &
                         (~flag_qw_empty | (drain_q & ~flag_empty));
      O_HOST_OUT.data = mem_q[rd_ptr_q[7:0]];
      O_SCSI_OUT.data = mem_q[rd_ptr_q[7:0]];
      wr_en = seq_wr;
      wr_data = I_WDATA;
      if (O_HOST_IN_READY && I_HOST_IN.valid) begin
         wr_en = 1'b1;
         wr_data = I_HOST_IN.data;
      end else if (O_SCSI_IN_READY && I_SCSI_IN.valid) begin
         wr_en = 1'b1;
         wr_data = I_SCSI_IN.data;
      end
      rd_en = seq_rd | (O_HOST_OUT.valid & I_HOST_OUT_READY) |
              (O_SCSI_OUT.valid & I_SCSI_OUT_READY);
   end

   // byte storage
   always_ff @(posedge I_CLK_SYS) begin
      if (wr_en) begin
         mem_q[wr_ptr_q[7:0]] <= wr_data;
      end
   end

   // pointers: clear loads both with the host byte offset
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wr_ptr_q <= 9'h000;
         rd_ptr_q <= 9'h000;
      end else if (clr_wr) begin
         wr_ptr_q <= {6'h00, haddr0_q[2:0]};
         rd_ptr_q <= {6'h00, haddr0_q[2:0]};
      end else if (soft_q || I_BUS_RESET) begin
         wr_ptr_q <= 9'h000;
         rd_ptr_q <= 9'h000;
      end else begin
         if (wr_en) begin
            wr_ptr_q <= wr_ptr_q + 9'h001;
         end
         if (rd_en) begin
            rd_ptr_q <= rd_ptr_q + 9'h001;
         end
      end
   end

   // ----------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------
   // read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_RDATA <= DFPC_RESET_BYTE;
      end else if (!I_RD) begin
         O_RDATA <= DFPC_RESET_BYTE;
      end else begin
         unique case (I_ADDR)
            DFPC_OFS_CONTROL: O_RDATA <= {1'b0, wide_odd_q, ack_q,
                                          dir_ack_q, drain_q, 1'b0};
            DFPC_OFS_STATUS: O_RDATA <= status;
            DFPC_OFS_CACHE_SIZE: O_RDATA <= cls_q;
            DFPC_OFS_HOST_ADDR0: O_RDATA <= haddr0_q;
            DFPC_OFS_BLOCK_CTRL: O_RDATA <= {7'h00, auto_dis_q};
            DFPC_OFS_DATA_PORT: O_RDATA <= seq_rd ?
                                   mem_q[rd_ptr_q[7:0]] : DFPC_RESET_BYTE;
            default: O_RDATA <= DFPC_RESET_BYTE;
         endcase
      end
   end

   // offset load pulse to host and scsi blocks
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_OFFSET_LOAD <= 1'b0;
         O_BYTE_OFFSET <= 3'h0;
      end else begin
         O_OFFSET_LOAD <= clr_wr;
         if (clr_wr) begin
            O_BYTE_OFFSET <= haddr0_q[2:0];
         end
      end
   end

   assign O_HOST_XFER_EN = ack_q[0];
   assign O_SCSI_DMA_EN = ack_q[1];
   assign O_SCSI_BUS_EN = ack_q[2];
   assign O_PATH_FLOW = dir_ack_q;
   assign O_DRAIN_ACTIVE = drain_q;
   assign O_WIDE_ODD = wide_odd_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_ARST_N);

   sequence s_clear_write;
      clr_wr && !I_BUS_RESET;
   endsequence
   sequence s_cleared_state;
      flag_empty && flag_qw_empty && !flag_full && !drain_q;
   endsequence

   chk_dir_ack_hold: assert property (
      (en_q != 3'h0 || ack_q != 3'h0) |=> $stable(dir_ack_q))
      else $error("direction ack moved while enabled");
   chk_drain_empty_ign: assert property (
      (!drain_q && flag_empty && !force_clr) |=> !drain_q)
      else $error("drain set while fifo empty");
   chk_drain_dir_inert: assert property (
      (!drain_q && dir_ack_q && !hw_idle && $stable(dir_ack_q))
      |=> !drain_q)
      else $error("drain set during host to scsi transfer");
   chk_drain_completes: assert property (
      (drain_q && flag_empty && !drain_set) |=> !drain_q)
      else $error("drain pending after fifo emptied");
   chk_auto_drain: assert property (
      (I_SCSI_COUNT_ZERO && !auto_dis_q && !dir_ack_q && !flag_empty
       && !clr_wr && !force_clr) |=> drain_q)
      else $error("auto drain not started");
   chk_clear_flags: assert property (
      s_clear_write |=> s_cleared_state ##1 (!clear_q || $past(clr_wr)))
      else $error("clear strobe did not empty fifo");
   chk_offset_load: assert property (
      s_clear_write |=> O_OFFSET_LOAD && count == 9'h000 &&
      wr_ptr_q[2:0] == $past(haddr0_q[2:0]))
      else $error("byte offset not loaded");
   chk_status_bit7: assert property (
      I_RD && reg_hit(I_ADDR, DFPC_OFS_STATUS) |=> !O_RDATA[7])
      else $error("status bit seven not zero");
   chk_cache_small: assert property (
      (!dir_ack_q && cls_q < DFPC_CLS_8) |->
      flag_cache == (count >= DFPC_TH_16))
      else $error("cache flag wrong for small line");
   chk_cache_large: assert property (
      (dir_ack_q && cls_q >= DFPC_CLS_32) |->
      flag_cache == (free >= DFPC_TH_128))
      else $error("cache flag wrong for large line");
   chk_seq_port_write: assert property (
      (seq_wr && !rd_en && !clr_wr && !force_clr && hw_idle) |=>
      count == $past(count) + 9'h001)
      else $error("sequencer write not stored");

endmodule // dfpc_top

// ==== dv/dfpc_far_model.sv ====
// dfpc_far_model: host and scsi blocks on the far side of the fifo
// assumes one clock; the bench queues source bytes through push()
`timescale 1ns/1ps
module dfpc_far_model
   import dfpc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_hold,
   input wire logic i_host_in_ready,
   input wire logic i_scsi_in_ready,
   output dfpc_byte_s o_host_in,
   output dfpc_byte_s o_scsi_in,
   output logic o_host_out_ready,
   output logic o_scsi_out_ready
);
   logic [7:0] q_host[$];
   logic [7:0] q_scsi[$];

   // ----------------------------------------------------------------
   // byte sources and sinks
   // ----------------------------------------------------------------
   // queue a byte on the host side (0) or the scsi side (1)
   task automatic push(input int side, input logic [7:0] d);
      if (side == 0) q_host.push_back(d);
      else q_scsi.push_back(d);
   endtask

   // quiet lines at time zero
   initial begin
      o_host_in = '0;
      o_scsi_in = '0;
      o_host_out_ready = 1'b0;
      o_scsi_out_ready = 1'b0;
   end

   // hold each byte until taken; idle data flips so it is never stale
   always @(posedge i_clk) begin
      if (o_host_in.valid && i_host_in_ready) q_host.delete(0);
      if (o_scsi_in.valid && i_scsi_in_ready) q_scsi.delete(0);
      o_host_in <= (q_host.size() > 0) ? {1'b1, q_host[0]} :
         {1'b0, ~o_host_in.data};
      o_scsi_in <= (q_scsi.size() > 0) ? {1'b1, q_scsi[0]} :
         {1'b0, ~o_scsi_in.data};
      // sinks stall one cycle in four, and fully while held
      o_host_out_ready <= !i_hold && ($urandom % 4 != 0);
      o_scsi_out_ready <= !i_hold && ($urandom % 4 != 0);
   end
endmodule // dfpc_far_model

// ==== dv/testbench.sv ====
// testbench: self-checking bench for the data fifo path control
// assumes dfpc_far_model plays the host and scsi blocks
`timescale 1ns/1ps
module testbench
   import dfpc_pkg::*;
;
   logic clk, arst_n, bus_wr, bus_rd, hold, rd_seen;
   logic [7:0] addr, wdata, rdata, a, d;
   logic [7:0] pat[10];
   logic [2:0] ofs;
   logic [15:0] mon_e;
   dfpc_byte_s host_in, scsi_in, host_out, scsi_out;
   logic host_in_rdy, scsi_in_rdy, host_out_rdy, scsi_out_rdy;
   logic cnt_zero, phase, bus_rst, mreq, host_done_flag, fill_th;
   logic host_en, sdma_en, sbus_en, path, drain, wide, load;
   int n_errors, tests_run, loads, l0, i, k, th, seed_v;
   int th_out[4] = '{16, 32, 64, 128};
   int th_in[4] = '{32, 32, 64, 128};
   int cls_lo[4] = '{0, 8, 16, 32};
   int cls_span[4] = '{8, 8, 16, 224};
   logic [15:0] exp_q[$];
   logic [7:0] out_q[$];

   dfpc_top dfpc_top_i (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(bus_wr), .I_RD(bus_rd), .O_RDATA(rdata),
      .I_HOST_IN(host_in), .O_HOST_IN_READY(host_in_rdy),
      .O_HOST_OUT(host_out), .I_HOST_OUT_READY(host_out_rdy),
      .I_SCSI_IN(scsi_in), .O_SCSI_IN_READY(scsi_in_rdy),
      .O_SCSI_OUT(scsi_out), .I_SCSI_OUT_READY(scsi_out_rdy),
      .I_SCSI_COUNT_ZERO(cnt_zero), .I_PHASE_CHANGE(phase),
      .I_BUS_RESET(bus_rst), .I_MEM_REQ_PENDING(mreq),
      .I_HOST_DONE(host_done_flag), .I_FILL_THRESHOLD(fill_th),
      .O_HOST_XFER_EN(host_en), .O_SCSI_DMA_EN(sdma_en),
      .O_SCSI_BUS_EN(sbus_en), .O_PATH_FLOW(path), .O_DRAIN_ACTIVE(drain),
      .O_WIDE_ODD(wide), .O_OFFSET_LOAD(load), .O_BYTE_OFFSET(ofs));

   dfpc_far_model dfpc_far_model_i (.i_clk(clk), .i_hold(hold),
      .i_host_in_ready(host_in_rdy), .i_scsi_in_ready(scsi_in_rdy),
      .o_host_in(host_in), .o_scsi_in(scsi_in),
      .o_host_out_ready(host_out_rdy), .o_scsi_out_ready(scsi_out_rdy));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] got, exp, mask, input string s);
      tests_run++;
      if ((got & mask) !== (exp & mask)) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, s, got, exp);
      end
   endtask

   task automatic take(input logic [7:0] got);
      if (out_q.size() == 0) begin
         n_errors++;
         $display("BAD %0t unexpected byte %h", $time, got);
      end else begin
         check(got, out_q.pop_front(), 8'hFF, "byte");
      end
   endtask

   task automatic reg_wr(input logic [7:0] ad, dt);
      @(posedge clk);
      addr <= ad;
      wdata <= dt;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] ad, exp, mask);
      @(posedge clk);
      addr <= ad;
      bus_rd <= 1'b1;
      exp_q.push_back({mask, exp});
      @(posedge clk);
      bus_rd <= 1'b0;
   endtask

   task automatic fill(input int n);
      repeat (n) reg_wr(DFPC_OFS_DATA_PORT, 8'($urandom));
   endtask

   task automatic wdrain(input logic v);
      for (int j = 0; j < 60 && drain !== v; j++) @(posedge clk);
      check({7'h00, drain}, {7'h00, v}, 8'h01, "drain");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // processes
   // ----------------------------------------------------------------
   // clock of 4 ns
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // compare read answers and delivered bytes against the noted values
   always @(posedge clk) begin
      if (rd_seen) begin
         mon_e = exp_q.pop_front();
         check(rdata, mon_e[7:0], mon_e[15:8], "read");
      end
      rd_seen <= bus_rd;
      if (host_out.valid && host_out_rdy) take(host_out.data);
      if (scsi_out.valid && scsi_out_rdy) take(scsi_out.data);
      loads <= loads + int'(load);
   end

   // cut a hang short
   initial begin
      #100000;
      n_errors++;
      $display("BAD %0t timeout", $time);
      conclude();
   end

   // main sequence
   initial begin
      {bus_wr, bus_rd, hold, rd_seen, cnt_zero, phase, bus_rst} = '0;
      {addr, wdata, mreq, host_done_flag, fill_th, arst_n} = '0;
      {n_errors, tests_run, loads} = '0;
      seed_v = $urandom(32'h0000_ad53);
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      {mreq, host_done_flag, fill_th} <= 3'($urandom);
      @(posedge clk);
      reg_rd(DFPC_OFS_CONTROL, 8'h00, 8'hFF);
      reg_rd(DFPC_OFS_STATUS, {3'h1, mreq, host_done_flag, fill_th, 2'h1}, 8'hFF);
      reg_rd(8'h00, 8'h00, 8'hFF);
      reg_wr(DFPC_OFS_STATUS, 8'hFF);
      reg_rd(DFPC_OFS_STATUS, {3'h1, mreq, host_done_flag, fill_th, 2'h1}, 8'hFF);
      $display("done reset map");
      // sequencer port in both directions, then a host to scsi stream
      for (k = 0; k < 2; k++) begin
         reg_wr(DFPC_OFS_CONTROL, 8'({k[0], 2'b01}));
         repeat (3) @(posedge clk);
         for (i = 0; i < 10; i++) begin
            pat[i] = 8'($urandom);
            reg_wr(DFPC_OFS_DATA_PORT, pat[i]);
         end
         for (i = 0; i < 10; i++) reg_rd(DFPC_OFS_DATA_PORT, pat[i], 8'hFF);
         reg_rd(DFPC_OFS_CONTROL, 8'({k[0], 2'b00}), 8'h04);
      end
      reg_wr(DFPC_OFS_CONTROL, 8'h1C);
      for (i = 0; i < 16; i++) begin
         d = 8'($urandom);
         dfpc_far_model_i.push(0, d);
         out_q.push_back(d);
      end
      // a partial quad word of seven bytes stays behind without a drain
      for (i = 0; i < 200 && out_q.size() > 7; i++) @(posedge clk);
      repeat (8) @(posedge clk);
      check(8'(out_q.size()), 8'h07, 8'hFF, "stream");
      out_q.delete();
      reg_wr(DFPC_OFS_CONTROL, 8'h08);
      repeat (4) @(posedge clk);
      check({7'h00, path}, 8'h01, 8'h01, "ack held");
      reg_wr(DFPC_OFS_CONTROL, 8'h00);
      repeat (4) @(posedge clk);
      check({7'h00, path}, 8'h00, 8'h01, "ack moved");
      // enable acks and wide odd show on their pins and read back
      reg_wr(DFPC_OFS_CONTROL, 8'h69);
      repeat (2) @(posedge clk);
      check({4'h0, wide, sbus_en, sdma_en, host_en}, 8'h0D, 8'h0F, "acks");
      reg_rd(DFPC_OFS_CONTROL, 8'h68, 8'hFF);
      reg_wr(DFPC_OFS_CONTROL, 8'h00);
      $display("done direction");
      // cache threshold just below and at each boundary, both directions
      for (k = 0; k < 2; k++) begin
         for (i = 0; i < 4; i++) begin
            th = k ? th_in[i] : th_out[i];
            reg_wr(DFPC_OFS_CONTROL, 8'({k[0], 2'b01}));
            reg_wr(DFPC_OFS_CACHE_SIZE, 8'(cls_lo[i] + $urandom % cls_span[i]));
            repeat (3) @(posedge clk);
            fill(k ? 256 - th : th - 1);
            reg_rd(DFPC_OFS_STATUS, 8'({k[0], 6'h00}), 8'h40);
            fill(1);
            reg_rd(DFPC_OFS_STATUS, 8'({~k[0], 6'h00}), 8'h40);
         end
      end
      $display("done cache threshold");
      // full before the clear strobe, nine bytes before bus reset and soft reset, then empty again after each
      for (k = 0; k < 3; k++) begin
         reg_wr(DFPC_OFS_CONTROL, 8'h01);
         fill(k == 0 ? 256 : 9);
         reg_rd(DFPC_OFS_STATUS, 8'h02, k == 0 ? 8'h23 : 8'h21);
         a = 8'($urandom);
         reg_wr(DFPC_OFS_HOST_ADDR0, a);
         l0 = loads;
         if (k == 0) begin
            reg_wr(DFPC_OFS_CONTROL, 8'h01);
         end else if (k == 1) begin
            bus_rst <= 1'b1;
            @(posedge clk);
            bus_rst <= 1'b0;
         end else begin
            reg_wr(DFPC_OFS_BLOCK_CTRL, 8'h02);
         end
         repeat (3) @(posedge clk);
         reg_rd(DFPC_OFS_STATUS, 8'h21, 8'h23);
         reg_rd(DFPC_OFS_DATA_PORT, 8'h00, 8'hFF);
         if (k == 0) begin
            check(8'(loads - l0), 8'h01, 8'hFF, "load pulse");
            check({5'h00, ofs}, {5'h00, a[2:0]}, 8'h07, "offset");
         end
      end
      reg_rd(DFPC_OFS_CONTROL, 8'h00, 8'h01);
      reg_rd(DFPC_OFS_BLOCK_CTRL, 8'h00, 8'h02);
      $display("done clear");
      // manual drain: refused when empty, then leftover bytes to host
      reg_wr(DFPC_OFS_CONTROL, 8'h02);
      reg_rd(DFPC_OFS_CONTROL, 8'h00, 8'h02);
      reg_wr(DFPC_OFS_CONTROL, 8'h18);
      for (i = 0; i < 3; i++) begin
         d = 8'($urandom);
         dfpc_far_model_i.push(1, d);
         out_q.push_back(d);
      end
      repeat (12) @(posedge clk);
      check(8'(out_q.size()), 8'h03, 8'hFF, "partial held");
      hold <= 1'b1;
      reg_wr(DFPC_OFS_CONTROL, 8'h1A);
      reg_rd(DFPC_OFS_CONTROL, 8'h02, 8'h02);
      hold <= 1'b0;
      wdrain(1'b0);
      reg_rd(DFPC_OFS_CONTROL, 8'h00, 8'h02);
      check(8'(out_q.size()), 8'h00, 8'hFF, "drained");
      // sequencer partial quad word released by drain
      reg_wr(DFPC_OFS_CONTROL, 8'h04);
      repeat (3) @(posedge clk);
      for (i = 0; i < 5; i++) begin
         d = 8'($urandom);
         reg_wr(DFPC_OFS_DATA_PORT, d);
         out_q.push_back(d);
      end
      reg_wr(DFPC_OFS_CONTROL, 8'h06);
      reg_wr(DFPC_OFS_CONTROL, 8'h14);
      wdrain(1'b0);
      check(8'(out_q.size()), 8'h00, 8'hFF, "partial out");
      // drain has no effect while moving host to scsi
      reg_wr(DFPC_OFS_CONTROL, 8'h0C);
      for (i = 0; i < 3; i++) dfpc_far_model_i.push(0, 8'($urandom));
      repeat (8) @(posedge clk);
      reg_wr(DFPC_OFS_CONTROL, 8'h0E);
      reg_rd(DFPC_OFS_CONTROL, 8'h00, 8'h02);
      reg_wr(DFPC_OFS_CONTROL, 8'h05);
      reg_wr(DFPC_OFS_CONTROL, 8'h00);
      repeat (4) @(posedge clk);
      $display("done manual drain");
      // auto drain on phase change, on count zero, and disabled
      reg_wr(DFPC_OFS_CONTROL, 8'h18);
      for (k = 0; k < 3; k++) begin
         if (k == 2) reg_wr(DFPC_OFS_BLOCK_CTRL, 8'h01);
         for (i = 0; i < 2; i++) begin
            d = 8'($urandom);
            dfpc_far_model_i.push(1, d);
            if (k < 2) out_q.push_back(d);
         end
         repeat (8) @(posedge clk);
         phase <= (k != 1);
         cnt_zero <= (k == 1);
         @(posedge clk);
         phase <= 1'b0;
         cnt_zero <= 1'b0;
         if (k < 2) begin
            wdrain(1'b1);
            wdrain(1'b0);
         end else begin
            repeat (8) @(posedge clk);
            check({7'h00, drain}, 8'h00, 8'h01, "auto off");
         end
         check(8'(out_q.size()), 8'h00, 8'hFF, "auto out");
      end
      reg_wr(DFPC_OFS_CONTROL, 8'h01);
      reg_wr(DFPC_OFS_BLOCK_CTRL, 8'h00);
      $display("done auto drain");
      repeat (10) @(posedge clk);
      conclude();
   end
endmodule // testbench
